/* File: fault_sleep_cfg.svh */
// register offsets, field positions and reset values of the fault and sleep control block
// assumes a 32-bit Avalon-MM slave with word addressing by byte address
`ifndef FAULT_SLEEP_CFG_SVH
`define FAULT_SLEEP_CFG_SVH
`define OFS_HARD_STATUS     8'h00
`define OFS_MEM_STATUS      8'h04
`define OFS_BUS_STATUS      8'h08
`define OFS_USAGE_STATUS    8'h0C
`define OFS_MEM_ADDR        8'h10
`define OFS_BUS_ADDR        8'h14
`define OFS_SYS_CTRL        8'h18
`define OFS_FAULT_PRIO      8'h1C
`define OFS_HANDLER_EN      8'h20
`define OFS_CORE_STATE      8'h24
`define BIT_VECTOR_READ_ERROR_FLAG_READ       0
`define BIT_ESCALATED       1
`define BIT_SLEEP_EXIT      1
`define BIT_DEEP_SLEEP      2
`define BIT_EVENT_PEND      4
`define PRIO_RESET          12'h000
`define EN_RESET            3'h0
`define SYSTEM_CONTROL_REG_RESET       3'h0
// packed positions inside the stored control bits
`define CTRL_EXIT_POS       0
`define CTRL_DEEP_POS       1
`define CTRL_EVP_POS        2
`endif

/* File: fault_sleep_pkg.sv */
// types shared by the fault and sleep control block
// assumes fault_sleep_cfg.svh holds the numeric constants
package fault_sleep_pkg;
   typedef logic [3:0]  prio_t;
   typedef logic [31:0] word_t;
   typedef enum logic [3:0] {
      RUN_ST   = 4'b0001,
      SLEEP_ST = 4'b0010,
      DEEP_ST  = 4'b0100,
      LOCK_ST  = 4'b1000
   } core_state_e;
   typedef enum logic [1:0] {
      WAKE_INT = 2'h0,
      WAKE_EVT = 2'h1
   } wake_cause_e;
endpackage

/* File: fault_sleep_ctrl.sv */
// fault classification, escalation, lockup and sleep control of an embedded core
// assumes fault strobes, priorities and masks from core logic on ref_clk, bus on ref_clk
//
// Function
// - fault raised on bus, internal, no-execute or protection errors
// - vector bus error gives hard fault, sets vector flag; escalation sets escalated flag
// - protection mismatch gives memory fault with four cause flags
// - no-execute fetch sets instruction flag even with protection disabled
// - bus errors give bus fault with five cause flags
// - six usage fault causes, each with its own flag
// - bad state on foreign instruction set or continuation return
// - configurable faults have software priority and enable
// - escalate when priority not above current, same type, or disabled; the priority test applies only inside a handler
// - bus fault on push into bus fault handler does not escalate
// - hard fault fixed priority, preempts all but reset, nmi, hard fault
// - capture faulting address for bus and memory faults; captured only on precise bus errors and on data, push or pop protection errors
// - hard fault in nmi or hard handler enters lockup, no execution
// - lockup left by reset, debug halt, or nmi unless entered from nmi
// - sleep stops core clock; deep sleep stops system clock, pll, flash
// - deep sleep select bit chooses sleep depth
// - wait-interrupt sleeps at once unless wake condition true
// - wait-event clears set event bit, else sleeps
// - event bit set by send-event, not software accessible
// - sleep after handlers returns to thread and sleeps
// - wake on entry-able exception; primary mask defers handler
// - wait-event wakes on exception or new pending with event bit
// - sufficient priority only above all mask limits
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fault_sleep_cfg.svh"
module fault_sleep_ctrl (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   // register bus
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   // bus fabric errors
   input  wire logic                  busErrVector,
   input  wire logic                  busErrPush,
   input  wire logic                  busErrPop,
   input  wire logic                  busErrFetch,
   input  wire logic                  busErrPrecise,
   input  wire logic                  busErrDeferred,
   input  wire fault_sleep_pkg::word_t busErrAddr,
   // protection unit and no-execute checks
   input  wire logic                  mpuErrInstr,
   input  wire logic                  mpuErrData,
   input  wire logic                  mpuErrPush,
   input  wire logic                  mpuErrPop,
   input  wire logic                  noExecFetch,
   input  wire fault_sleep_pkg::word_t mpuErrAddr,
   // decoder errors
   input  wire logic                  coprocAccess,
   input  wire logic                  unknownOpcode,
   input  wire logic                  foreignIsa,
   input  wire logic                  badContinuation,
   input  wire logic                  badReturnValue,
   input  wire logic                  misalignedAccess,
   input  wire logic                  zeroDivisor,
   // instructions and execution context
   input  wire logic                  waitInterruptInstr,
   input  wire logic                  waitEventInstr,
   input  wire logic                  sendEventInstr,
   input  wire logic                  handlersDone,
   input  wire logic                  inNmiHandler,
   input  wire logic                  inHardHandler,
   input  wire logic                  inMemHandler,
   input  wire logic                  inBusHandler,
   input  wire logic                  inUsageHandler,
   input  wire logic                  busHandlerEntry,
   input  wire fault_sleep_pkg::prio_t currentPrio,
   // interrupt controller
   input  wire logic                  pendValid,
   input  wire fault_sleep_pkg::prio_t pendPrio,
   input  wire logic                  pendEnabled,
   input  wire logic                  newPending,
   input  wire logic                  primaryMask,
   input  wire logic                  faultMaskBit,
   input  wire fault_sleep_pkg::prio_t basePrio,
   input  wire logic                  nmiReq,
   input  wire logic                  debugHalt,
   // fault and power outputs
   output logic                       hardFaultReq,
   output logic                       memFaultReq,
   output logic                       busFaultReq,
   output logic                       usageFaultReq,
   output logic                       coreHalted,
   output logic                       lockedUp,
   output logic                       handlerDeferred,
   output logic                       coreClkEn,
   output logic                       sysClkEn,
   output logic                       pllEn,
   output logic                       flashEn
);
   import fault_sleep_pkg::*;

   // ***********************************
   // registers
   // ***********************************
   logic [1:0]  hardStatus_reg;
   logic [3:0]  memStatus_reg;
   logic [4:0]  busStatus_reg;
   logic [5:0]  usageStatus_reg;
   word_t       memAddr_reg;
   word_t       busAddr_reg;
   logic [2:0]  system_control_reg_reg;
   logic [11:0] faultPrio_reg;
   logic [2:0]  handlerEn_reg;
   logic        eventBit_reg;
   logic        lockFromNmi_reg;
   logic        ack_reg;
   core_state_e state_reg;
   core_state_e state_next;

   // ***********************************
   // fault classification
   // ***********************************
   wire memCause    = mpuErrInstr | noExecFetch | mpuErrData | mpuErrPush | mpuErrPop;
   wire busCause    = busErrPush | busErrPop | busErrFetch | busErrPrecise | busErrDeferred;
   wire badState    = foreignIsa | badContinuation;
   wire usageCause  = coprocAccess | unknownOpcode | badState | badReturnValue
                      | misalignedAccess | zeroDivisor;
   wire [3:0] memNew  = {mpuErrPop, mpuErrPush, mpuErrData, mpuErrInstr | noExecFetch};
   wire [4:0] busNew  = {busErrDeferred, busErrPrecise, busErrFetch, busErrPop, busErrPush};
   wire [5:0] usgNew  = {zeroDivisor, misalignedAccess, badReturnValue, badState,
                         unknownOpcode, coprocAccess};

   // ***********************************
   // escalation
   // ***********************************
   wire prio_t memPrio   = prio_t'(faultPrio_reg[3:0]);
   wire prio_t busPrio   = prio_t'(faultPrio_reg[7:4]);
   wire prio_t usagePrio = prio_t'(faultPrio_reg[11:8]);
   wire inHandler = inNmiHandler | inHardHandler | inMemHandler | inBusHandler | inUsageHandler;
   // lower value is higher priority; equal or numerically larger cannot preempt
   wire memEsc   = memCause & (~handlerEn_reg[0] | inMemHandler
                   | (inHandler & (memPrio >= currentPrio)));
   wire busStackOk = busHandlerEntry & busErrPush;
   wire busEsc   = busCause & ~busStackOk & (~handlerEn_reg[1] | inBusHandler
                   | (inHandler & (busPrio >= currentPrio)));
   wire usageEsc = usageCause & (~handlerEn_reg[2] | inUsageHandler
                   | (inHandler & (usagePrio >= currentPrio)));
   wire escalate = memEsc | busEsc | usageEsc;
   wire hardNow  = busErrVector | escalate;
   // hard fault inside nmi or hard handler cannot preempt: lock up
   wire lockEnter = hardNow & (inNmiHandler | inHardHandler);

   // ***********************************
   // wake and priority
   // ***********************************
   wire maskBlocks = primaryMask | faultMaskBit
                     | ((basePrio != 4'h0) & (pendPrio >= basePrio));
   wire entryable  = pendValid & pendEnabled & ~maskBlocks & (pendPrio < currentPrio);
   // primary mask set, fault mask clear: wake but hold the handler
   wire deferWake  = pendValid & pendEnabled & primaryMask & ~faultMaskBit
                     & (pendPrio < currentPrio);
   wire wakeInt    = entryable | deferWake;
   wire eventSet   = sendEventInstr | (system_control_reg_reg[`CTRL_EVP_POS] & newPending);
   wire asleep     = (state_reg == SLEEP_ST) | (state_reg == DEEP_ST);
   wire goSleep    = (waitInterruptInstr & ~wakeInt)
                     | (waitEventInstr & ~eventBit_reg & ~entryable)
                     | (handlersDone & system_control_reg_reg[`CTRL_EXIT_POS]);
   wire wakeNow    = wakeInt | (eventSet & system_control_reg_reg[`CTRL_EVP_POS]);
   wire lockExit   = debugHalt | (nmiReq & ~lockFromNmi_reg);
   wire core_state_e sleepState = system_control_reg_reg[`CTRL_DEEP_POS] ? DEEP_ST : SLEEP_ST;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RUN_ST: begin
            if (lockEnter)
               state_next = LOCK_ST;
            else if (goSleep)
               state_next = sleepState;
         end
         SLEEP_ST,
         DEEP_ST: begin
            if (wakeNow)
               state_next = RUN_ST;
         end
         LOCK_ST: begin
            if (lockExit)
               state_next = RUN_ST;
         end
         default: state_next = RUN_ST;
      endcase
   end

   // ***********************************
   // register bus decode
   // ***********************************
   wire selHard  = (avs_address == `OFS_HARD_STATUS);
   wire selMem   = (avs_address == `OFS_MEM_STATUS);
   wire selBus   = (avs_address == `OFS_BUS_STATUS);
   wire selUsage = (avs_address == `OFS_USAGE_STATUS);
   wire selMAddr = (avs_address == `OFS_MEM_ADDR);
   wire selBAddr = (avs_address == `OFS_BUS_ADDR);
   wire selCtrl  = (avs_address == `OFS_SYS_CTRL);
   wire selPrio  = (avs_address == `OFS_FAULT_PRIO);
   wire selEn    = (avs_address == `OFS_HANDLER_EN);
   wire selState = (avs_address == `OFS_CORE_STATE);
   wire wrTake   = avs_write & ~ack_reg & avs_byteenable[0];
   wire rdTake   = avs_read & ~ack_reg;
   wire word_t rdMux =
        selHard  ? word_t'(hardStatus_reg) :
        selMem   ? word_t'(memStatus_reg) :
        selBus   ? word_t'(busStatus_reg) :
        selUsage ? word_t'(usageStatus_reg) :
        selMAddr ? memAddr_reg :
        selBAddr ? busAddr_reg :
        selCtrl  ? word_t'(system_control_reg_reg) :
        selPrio  ? word_t'(faultPrio_reg) :
        selEn    ? word_t'(handlerEn_reg) :
        selState ? word_t'(state_reg) :
        32'h0000_0000;
   // write-one-to-clear on status; new events win over the clear
   wire [1:0] hardClr  = (wrTake & selHard)  ? avs_writedata[1:0] : 2'h0;
   wire [3:0] memClr   = (wrTake & selMem)   ? avs_writedata[3:0] : 4'h0;
   wire [4:0] busClr   = (wrTake & selBus)   ? avs_writedata[4:0] : 5'h00;
   wire [5:0] usageClr = (wrTake & selUsage) ? avs_writedata[5:0] : 6'h00;
   wire [1:0] hardNew  = {escalate, busErrVector};

   // ***********************************
   // sequential logic
   // ***********************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hardStatus_reg  <= 2'h0;
         memStatus_reg   <= 4'h0;
         busStatus_reg   <= 5'h00;
         usageStatus_reg <= 6'h00;
      end else begin
         hardStatus_reg  <= (hardStatus_reg & ~hardClr) | hardNew;
         memStatus_reg   <= (memStatus_reg & ~memClr) | memNew;
         busStatus_reg   <= (busStatus_reg & ~busClr) | busNew;
         usageStatus_reg <= (usageStatus_reg & ~usageClr) | usgNew;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         memAddr_reg <= 32'h0000_0000;
         busAddr_reg <= 32'h0000_0000;
      end else begin
         if (mpuErrData | mpuErrPush | mpuErrPop)
            memAddr_reg <= mpuErrAddr;
         if (busErrPrecise)
            busAddr_reg <= busErrAddr;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         system_control_reg_reg   <= `SYSTEM_CONTROL_REG_RESET;
         faultPrio_reg <= `PRIO_RESET;
         handlerEn_reg <= `EN_RESET;
      end else begin
         if (wrTake & selCtrl)
            system_control_reg_reg <= {avs_writedata[`BIT_EVENT_PEND], avs_writedata[`BIT_DEEP_SLEEP],
                            avs_writedata[`BIT_SLEEP_EXIT]};
         if (wrTake & selPrio)
            faultPrio_reg <= avs_writedata[11:0];
         if (wrTake & selEn)
            handlerEn_reg <= avs_writedata[2:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         eventBit_reg    <= 1'b0;
         lockFromNmi_reg <= 1'b0;
         state_reg       <= RUN_ST;
      end else begin
         state_reg <= state_next;
         // set wins over clear by the wait-event
         if (eventSet)
            eventBit_reg <= 1'b1;
         else if (waitEventInstr && state_reg == RUN_ST)
            eventBit_reg <= 1'b0;
         if (state_reg == RUN_ST && lockEnter)
            lockFromNmi_reg <= inNmiHandler;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_reg         <= 1'b0;
         avs_readdata    <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_reg         <= (rdTake | (avs_write & ~ack_reg));
         avs_waitrequest <= ~(rdTake | (avs_write & ~ack_reg));
         if (rdTake)
            avs_readdata <= rdMux;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hardFaultReq    <= 1'b0;
         memFaultReq     <= 1'b0;
         busFaultReq     <= 1'b0;
         usageFaultReq   <= 1'b0;
         coreHalted      <= 1'b0;
         lockedUp        <= 1'b0;
         handlerDeferred <= 1'b0;
         coreClkEn       <= 1'b1;
         sysClkEn        <= 1'b1;
         pllEn           <= 1'b1;
         flashEn         <= 1'b1;
      end else begin
         hardFaultReq    <= hardNow & ~lockEnter;
         memFaultReq     <= memCause & ~memEsc;
         busFaultReq     <= busCause & ~busEsc;
         usageFaultReq   <= usageCause & ~usageEsc;
         coreHalted      <= state_next != RUN_ST;
         lockedUp        <= state_next == LOCK_ST;
         handlerDeferred <= deferWake & ~entryable;
         coreClkEn       <= state_next == RUN_ST || state_next == LOCK_ST;
         sysClkEn        <= state_next != DEEP_ST;
         pllEn           <= state_next != DEEP_ST;
         flashEn         <= state_next != DEEP_ST;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   property p_vector_read_error_flag_flag;
      @(posedge ref_clk) disable iff (!nrst)
         (busErrVector && !lockEnter) |=> hardStatus_reg[0] && hardFaultReq;
   endproperty
   a_vector_read_error_flag_flag: assert property (p_vector_read_error_flag_flag) else $error("vector error not recorded");

   property p_nx_flag;
      @(posedge ref_clk) disable iff (!nrst) noExecFetch |=> memStatus_reg[0];
   endproperty
   a_nx_flag: assert property (p_nx_flag) else $error("no-execute flag missing");

   property p_sticky;
      @(posedge ref_clk) disable iff (!nrst)
         (busStatus_reg[3] && !(wrTake && selBus && avs_writedata[3])) |=> busStatus_reg[3];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_disabled_esc;
      @(posedge ref_clk) disable iff (!nrst)
         (usageCause && !handlerEn_reg[2] && !lockEnter) |=> hardFaultReq && !usageFaultReq;
   endproperty
   a_disabled_esc: assert property (p_disabled_esc) else $error("disabled fault not escalated");

   property p_stack_noesc;
      @(posedge ref_clk) disable iff (!nrst)
         (busHandlerEntry && busErrPush && handlerEn_reg[1]) |=> busFaultReq;
   endproperty
   a_stack_noesc: assert property (p_stack_noesc) else $error("stacking fault escalated");

   sequence s_lock_in;
      state_reg == RUN_ST && lockEnter;
   endsequence
   property p_lock;
      @(posedge ref_clk) disable iff (!nrst) s_lock_in |=> lockedUp && coreHalted;
   endproperty
   a_lock: assert property (p_lock) else $error("lockup not entered");

   property p_nmi_stay;
      @(posedge ref_clk) disable iff (!nrst)
         (state_reg == LOCK_ST && lockFromNmi_reg && !debugHalt) |=> state_reg == LOCK_ST;
   endproperty
   a_nmi_stay: assert property (p_nmi_stay) else $error("nmi left nmi lockup");

   property p_deep;
      @(posedge ref_clk) disable iff (!nrst)
         state_reg == DEEP_ST |-> !sysClkEn && !pllEn && !flashEn && !coreClkEn;
   endproperty
   a_deep: assert property (p_deep) else $error("deep sleep clocks running");

   property p_wfe_set;
      @(posedge ref_clk) disable iff (!nrst)
         (state_reg == RUN_ST && waitEventInstr && eventBit_reg && !lockEnter && !goSleep)
         |=> state_reg == RUN_ST;
   endproperty
   a_wfe_set: assert property (p_wfe_set) else $error("slept with event set");

   property p_wfi;
      @(posedge ref_clk) disable iff (!nrst)
         (state_reg == RUN_ST && waitInterruptInstr && !wakeInt && !lockEnter)
         |=> coreHalted ##1 !coreClkEn;
   endproperty
   a_wfi: assert property (p_wfi) else $error("wait-interrupt did not sleep");
endmodule
`default_nettype wire

/* File: far_side_model.sv */
// far side of the fault block: bus fabric, protection unit, decoder
// assumes ref_clk is shared; causes are one-cycle pulses, address valid with them
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   // clock
   input  wire logic                    ref_clk,
   // fault causes
   output logic [17:0]                  errP,
   output fault_sleep_pkg::word_t       busErrAddr,
   output fault_sleep_pkg::word_t       mpuErrAddr
);
   import fault_sleep_pkg::*;
   // ***********************
   // cause pulse generator
   // ***********************
   initial begin
      errP = 18'h0_0000;
      busErrAddr = 32'h0000_0000;
      mpuErrAddr = 32'h0000_0000;
   end
   task automatic fire(input int idx, input word_t a);
      @(posedge ref_clk);
      errP <= 18'h0_0001 << idx;
      busErrAddr <= a;
      mpuErrAddr <= a;
      @(posedge ref_clk);
      errP <= 18'h0_0000;
      // address no longer valid after the pulse
      busErrAddr <= ~a;
      mpuErrAddr <= ~a;
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the fault and sleep control block
// assumes far_side_model drives all fault causes; registers over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fault_sleep_pkg::*;
   // ***********************
   // signals
   // ***********************
   logic        ref_clk, nrst, avs_read, avs_write;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic        waitInterruptInstr, waitEventInstr, sendEventInstr, handlersDone;
   logic        inNmiHandler, inHardHandler, inMemHandler, inBusHandler, inUsageHandler;
   logic        busHandlerEntry, pendValid, pendEnabled, newPending, primaryMask;
   logic        faultMaskBit, nmiReq, debugHalt;
   prio_t       currentPrio, pendPrio, basePrio;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, hardFaultReq, memFaultReq, busFaultReq, usageFaultReq;
   wire         coreHalted, lockedUp, handlerDeferred, coreClkEn, sysClkEn, pllEn, flashEn;
   wire  [17:0] errP;
   wire word_t  busErrAddr, mpuErrAddr;
   wire         busErrVector, busErrPush, busErrPop, busErrFetch, busErrPrecise;
   wire         busErrDeferred, mpuErrInstr, mpuErrData, mpuErrPush, mpuErrPop;
   wire         noExecFetch, coprocAccess, unknownOpcode, foreignIsa, badContinuation;
   wire         badReturnValue, misalignedAccess, zeroDivisor;
   int          miscompares, n_tests, cyc;
   assign {zeroDivisor, misalignedAccess, badReturnValue, badContinuation, foreignIsa,
           unknownOpcode, coprocAccess, noExecFetch, mpuErrPop, mpuErrPush, mpuErrData,
           mpuErrInstr, busErrDeferred, busErrPrecise, busErrFetch, busErrPop, busErrPush,
           busErrVector} = errP;
   fault_sleep_ctrl uut (.*);
   far_side_model partner (.ref_clk(ref_clk), .errP(errP), .busErrAddr(busErrAddr),
                           .mpuErrAddr(mpuErrAddr));
   // ***********************
   // helpers
   // ***********************
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0000_0000, rd);
      chk(nm, exp, rd);
   endtask
   function automatic logic [3:0] reqs();
      return {hardFaultReq, memFaultReq, busFaultReq, usageFaultReq};
   endfunction
   // ***********************
   // scenarios
   // ***********************
   task automatic t_reset();
      for (int a = 0; a < 13; a++) rdchk("reset reg", 8'(a * 4), (a == 9) ? 32'h1 : 32'h0);
      chk("clocks at reset", 4'hF, {coreClkEn, sysClkEn, pllEn, flashEn});
      avs_byteenable <= 4'h0;
      wr(8'h1C, 32'h0000_0FFF);
      rdchk("masked write", 8'h1C, 32'h0000_0000);
      avs_byteenable <= 4'hF;
      wr(8'h1C, 32'h0000_0210);
      wr(8'h30, 32'hFFFF_FFFF);
      rdchk("priority reg", 8'h1C, 32'h0000_0210);
      $display("reset test done");
   endtask
   task automatic t_causes();
      wr(8'h20, 32'h0000_0007);
      for (int i = 1; i < 18; i++) begin
         partner.fire(i, 32'h1000_0000 + i);
         #1 chk("fault req", (i < 6) ? 4'h2 : (i < 11) ? 4'h4 : 4'h1, reqs());
      end
      rdchk("mem status", 8'h04, 32'h0000_000F);
      rdchk("bus status", 8'h08, 32'h0000_001F);
      rdchk("usage status", 8'h0C, 32'h0000_003F);
      rdchk("mem addr", 8'h10, 32'h1000_0009);
      rdchk("bus addr", 8'h14, 32'h1000_0004);
      rdchk("hard status", 8'h00, 32'h0000_0000);
      wr(8'h0C, 32'h0000_003F);
      rdchk("usage cleared", 8'h0C, 32'h0000_0000);
      wr(8'h08, 32'h0000_0008);
      rdchk("bus partial clear", 8'h08, 32'h0000_0017);
      $display("cause test done");
   endtask
   task automatic t_escalate();
      wr(8'h20, 32'h0000_0000);
      partner.fire(11, 32'h2000_0000);
      #1 chk("disabled handler", 4'h8, reqs());
      wr(8'h20, 32'h0000_0007);
      inMemHandler <= 1'b1;
      currentPrio <= 4'h3;
      partner.fire(16, 32'h0);
      #1 chk("higher prio fault", 4'h1, reqs());
      currentPrio <= 4'h1;
      partner.fire(16, 32'h0);
      #1 chk("lower prio fault", 4'h8, reqs());
      inMemHandler <= 1'b0;
      inBusHandler <= 1'b1;
      busHandlerEntry <= 1'b1;
      partner.fire(1, 32'h0);
      #1 chk("push into bus handler", 4'h2, reqs());
      busHandlerEntry <= 1'b0;
      partner.fire(0, 32'h0);
      #1 chk("vector error", 4'h8, reqs());
      inBusHandler <= 1'b0;
      rdchk("hard status", 8'h00, 32'h0000_0003);
      wr(8'h00, 32'h0000_0003);
      $display("escalation test done");
   endtask
   task automatic t_lockup();
      int n;
      for (int k = 0; k < 2; k++) begin
         inHardHandler <= (k == 0);
         inNmiHandler <= (k == 1);
         partner.fire(0, 32'h0);
         for (n = 0; n < 8 && lockedUp !== 1'b1; n++) @(posedge ref_clk);
         #1 chk("locked", 2'b11, {lockedUp, coreHalted});
         rdchk("state", 8'h24, 32'h0000_0008);
         nmiReq <= 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 chk("nmi exit", (k == 1), lockedUp);
         debugHalt <= 1'b1;
         for (n = 0; n < 8 && lockedUp !== 1'b0; n++) @(posedge ref_clk);
         #1 chk("halt exit", 1'b0, lockedUp);
         {nmiReq, debugHalt} <= 2'h0;
      end
      {inHardHandler, inNmiHandler} <= 2'h0;
      wr(8'h00, 32'h0000_0003);
      $display("lockup test done");
   endtask
   task automatic t_sleep();
      int n;
      logic [31:0] ctl [3] = '{32'h2, 32'h4, 32'h10};
      sendEventInstr <= 1'b1;
      @(posedge ref_clk) sendEventInstr <= 1'b0;
      waitEventInstr <= 1'b1;
      @(posedge ref_clk) waitEventInstr <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk("event skip", 1'b1, coreClkEn);
      for (int k = 0; k < 3; k++) begin
         wr(8'h18, ctl[k]);
         rdchk("sys ctrl", 8'h18, 32'h1 << k);
         handlersDone <= (k == 0);
         waitInterruptInstr <= (k == 1);
         waitEventInstr <= (k == 2);
         @(posedge ref_clk) {handlersDone, waitInterruptInstr, waitEventInstr} <= 3'h0;
         for (n = 0; n < 8 && coreClkEn !== 1'b0; n++) @(posedge ref_clk);
         #1 chk("asleep", (k == 1) ? 4'h0 : 4'h7, {coreClkEn, sysClkEn, pllEn, flashEn});
         newPending <= (k == 2);
         pendValid <= (k < 2);
         pendEnabled <= (k < 2);
         primaryMask <= (k < 2);
         @(posedge ref_clk) newPending <= 1'b0;
         for (n = 0; n < 8 && coreClkEn !== 1'b1; n++) @(posedge ref_clk);
         #1 chk("woken", {1'b1, k < 2}, {coreClkEn, handlerDeferred});
         {pendValid, pendEnabled, primaryMask} <= 3'h0;
         repeat (3) @(posedge ref_clk);
      end
      $display("sleep test done");
   endtask
   // ***********************
   // main sequence
   // ***********************
   initial begin
      {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hF;
      {waitInterruptInstr, waitEventInstr, sendEventInstr, handlersDone, inNmiHandler,
       inHardHandler, inMemHandler, inBusHandler, inUsageHandler, busHandlerEntry,
       pendValid, pendEnabled, newPending, primaryMask, faultMaskBit, nmiReq,
       debugHalt} = '0;
      {currentPrio, pendPrio, basePrio} = {4'hF, 4'h1, 4'h0};
      {miscompares, n_tests, cyc} = '0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_causes();
      t_escalate();
      t_lockup();
      currentPrio <= 4'hF;
      t_sleep();
      print_verdict();
   end
endmodule
`default_nettype wire
